// [pfs_edge_detect.sv]
// Per-channel valid edge detector with selectable rising, falling or both.
// Assumes levels already synchronous to clk_sys.
module pfs_edge_detect
    import pfs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    pfs_edge_if.det   edge_bus
);

    logic [PFS_EDGE_CH-1:0] prev_reg;
    logic [PFS_EDGE_CH-1:0] prev_next;
    logic [PFS_EDGE_CH-1:0] hit_reg;
    logic [PFS_EDGE_CH-1:0] hit_next;
    logic                   armed_reg;
    logic                   armed_next;

    // ------------------------------------------------------------
    // Edge decision
    // ------------------------------------------------------------
    // Armed one cycle after reset release: no false edge at release
    for (genvar g = 0; g < PFS_EDGE_CH; g++)
    begin : gCh
        pfs_edge_t chSel;
        logic      rise;
        logic      fall;
        assign chSel = pfs_edge_t'(edge_bus.sel[g*EDGE_SEL_W +: EDGE_SEL_W]);
        assign rise  = edge_bus.lvl[g] & ~prev_reg[g];
        assign fall  = ~edge_bus.lvl[g] & prev_reg[g];
        assign hit_next[g] = armed_reg &
                             (((chSel == PFS_EDGE_RISE) & rise) |
                              ((chSel == PFS_EDGE_FALL) & fall) |
                              ((chSel == PFS_EDGE_BOTH) & (rise | fall))); // see (RQ10)
    end

    always_comb
    begin
        prev_next  = edge_bus.lvl;
        armed_next = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_reg  <= '0;
            hit_reg   <= '0;
            armed_reg <= 1'b0;
        end
        else
        begin
            prev_reg  <= prev_next;
            hit_reg   <= hit_next;
            armed_reg <= armed_next;
        end
    end

    assign edge_bus.hit = hit_reg;

endmodule : pfs_edge_detect

// [pfs_edge_if.sv]
// Interface between the pin select top and its edge detector.
// Assumes both ends run on clk_sys.
interface pfs_edge_if;
    import pfs_pkg::*;

    logic [PFS_EDGE_CH-1:0]            lvl;
    logic [PFS_EDGE_CH*EDGE_SEL_W-1:0] sel;
    logic [PFS_EDGE_CH-1:0]            hit;

    modport det (input lvl, input sel, output hit);
    modport top (output lvl, output sel, input hit);

endinterface : pfs_edge_if

// [pfs_pin_model.sv]
// Board side of the port C pins: resolves each pin level from all drivers.
// Assumes the bench sets board levels at rising edges of clk_sys.
module pfs_pin_model
    import pfs_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic [PFS_NPIN-1:0] boardLvl,
    input  wire logic                open0,
    input  wire logic                pin0Out,
    input  wire logic                pin0Oe,
    input  wire logic                pin0PullUp,
    input  wire logic                pin2Out,
    input  wire logic                pin2Oe,
    output logic      [PFS_NPIN-1:0] pinLvl
);
    logic floatLvl = 1'b0;
    // Open pin toggles so a stale level never reads as valid
    always @(posedge clk_sys) floatLvl <= ~floatLvl;
    always_comb
    begin
        pinLvl = boardLvl;
        if (pin0Oe) pinLvl[0] = pin0Out;
        else if (open0) pinLvl[0] = pin0PullUp | floatLvl;
        if (pin2Oe) pinLvl[2] = pin2Out;
    end
endmodule : pfs_pin_model

// [pfs_pkg.sv]
// Constants, register map and types of the port C pin function select block.
// Assumes one system clock and a plain strobe register port with 8-bit data.
//
// Summary of operation
// (RQ1) Pin zero is a two-way port bit; pins one to five are input only.
// (RQ2) Reset pin mode bit five at 1 makes the reset pin a port bit.
// (RQ3) After reset release the reset pin is the reset input, so a low pin holds reset.
// (RQ4) As reset input the pin asserts reset while low and releases it while high.
// (RQ5) The alternate switch routes timer input and interrupt zero to pin one or five.
// (RQ6) The alternate switch can put the serial unit data output on pin zero.
// (RQ7) Each port bit takes its direction from its own direction register bit.
// (RQ8) Pull-ups exist only for pin zero and the reset pin.
// (RQ9) Port or alternate mode is chosen for each pin on its own; only the pin zero mode bit takes effect, bits one to five are stored only.
// (RQ10) Interrupt zero detects rising, falling or both edges, as software selects.
// (RQ11) The routed timer input feeds the timer count clock and its capture trigger.
// (RQ12) In tool use pin one carries the tool clock and pin two the tool data.
// (RQ13) The port driver never overrides an alternate function; pin levels reach all users.
package pfs_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PFS_AW      = 4;
    localparam int PFS_DW      = 8;
    localparam int PFS_NPIN    = 6;
    localparam int PFS_EDGE_CH = 2;
    localparam int PFS_NIRQ    = 2;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [PFS_AW-1:0] ADDR_PORT_DATA = 4'h0;
    localparam logic [PFS_AW-1:0] ADDR_PORT_DIR  = 4'h1;
    localparam logic [PFS_AW-1:0] ADDR_PULLUP    = 4'h2;
    localparam logic [PFS_AW-1:0] ADDR_PIN_MODE  = 4'h3;
    localparam logic [PFS_AW-1:0] ADDR_RST_MODE  = 4'h4;
    localparam logic [PFS_AW-1:0] ADDR_ALT_SW    = 4'h5;
    localparam logic [PFS_AW-1:0] ADDR_EDGE_SEL  = 4'h6;
    localparam logic [PFS_AW-1:0] ADDR_IRQ_STAT  = 4'h7;
    localparam logic [PFS_AW-1:0] ADDR_IRQ_CLR   = 4'h8;
    localparam logic [PFS_AW-1:0] ADDR_IRQ_EN    = 4'h9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN_ZERO          = 0;
    localparam int PIN_ONE           = 1;
    localparam int PIN_TWO           = 2;
    localparam int PIN_THREE         = 3;
    localparam int PIN_FOUR          = 4;
    localparam int PIN_FIVE          = 5;
    localparam int BIT_RST_AS_PORT   = 5;
    localparam int ALT_TMR_IRQ_P1    = 0;
    localparam int ALT_TMR_IRQ_P5    = 1;
    localparam int ALT_CSI_P0        = 2;
    localparam int IRQ_EXT_ZERO      = 0;
    localparam int IRQ_TIMER_IN      = 1;
    localparam int EDGE_SEL_W        = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PFS_DW-1:0]   RST_DATA      = 8'h00;
    localparam logic [PFS_NPIN-1:0] RST_PIN_MODE  = 6'h00;
    localparam logic [PFS_NPIN-1:0] DIR_INPUT_ALL = 6'h3F;
    localparam logic [2:0]          RST_ALT_SW    = 3'h0;
    localparam logic [3:0]          RST_EDGE_SEL  = 4'h0;
    localparam logic [PFS_NIRQ-1:0] RST_IRQ       = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PFS_EDGE_NONE = 2'h0,
        PFS_EDGE_RISE = 2'h1,
        PFS_EDGE_FALL = 2'h2,
        PFS_EDGE_BOTH = 2'h3
    } pfs_edge_t;

endpackage : pfs_pkg

// [pfs_port12_mux.sv]
// Pin function select for the six-bit port C: port bits, alternate routing,
// reset pin mode, pull-up choice and edge interrupts of the routed inputs.
// Assumes pin levels synchronous to clk_sys and a plain strobe register port.
//
// The placing of the registers and the address-and-strobe port were decided locally.
module pfs_port12_mux
    import pfs_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire logic [PFS_AW-1:0]   regAddr,
    input  wire logic [PFS_DW-1:0]   regWrData,
    input  wire logic                regWrStb,
    input  wire logic                regRdStb,
    output logic      [PFS_DW-1:0]   regRdData,
    input  wire logic [PFS_NPIN-1:0] pinIn,
    output logic                     pin0Out,
    output logic                     pin0Oe,
    output logic                     pin2Out,
    output logic                     pin2Oe,
    output logic                     pin0PullUp,
    output logic                     pin5PullUp,
    input  wire logic                progDebugMode,
    input  wire logic                progDebugDataOut,
    input  wire logic                progDebugDataOe,
    input  wire logic                csiSerialDataOut,
    output logic                     extIrqZeroIn,
    output logic                     extLowvoltDetectIn,
    output logic                     timerExtCountIn,
    output logic                     mainOscIn,
    output logic                     mainExtClkIn,
    output logic                     subOscIn,
    output logic                     subExtClkIn,
    output logic                     progDebugClkIn,
    output logic                     progDebugDataIn,
    output logic                     extResetInN,
    output logic                     irqOut
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                  portLatch_reg;
    logic                  portLatch_next;
    logic                  portDirC_reg;
    logic                  portDirC_next;
    logic                  pullupP0_reg;
    logic                  pullupP0_next;
    logic                  pullupP5_reg;
    logic                  pullupP5_next;
    logic [PFS_NPIN-1:0]   pinMode_reg;
    logic [PFS_NPIN-1:0]   pinMode_next;
    logic                  resetPinAsPortBit_reg;
    logic                  resetPinAsPortBit_next;
    logic [2:0]            altSwitchCtrl_reg;
    logic [2:0]            altSwitchCtrl_next;
    logic [3:0]            edgeSel_reg;
    logic [3:0]            edgeSel_next;
    logic [PFS_NIRQ-1:0]   irqStat_reg;
    logic [PFS_NIRQ-1:0]   irqStat_next;
    logic [PFS_NIRQ-1:0]   irqEn_reg;
    logic [PFS_NIRQ-1:0]   irqEn_next;
    logic [PFS_DW-1:0]     rdData_reg;
    logic [PFS_DW-1:0]     rdData_next;

    logic                  pin0Out_reg;
    logic                  pin0Out_next;
    logic                  pin0Oe_reg;
    logic                  pin0Oe_next;
    logic                  pin2Out_reg;
    logic                  pin2Out_next;
    logic                  pin2Oe_reg;
    logic                  pin2Oe_next;
    logic                  pin0PullUp_reg;
    logic                  pin0PullUp_next;
    logic                  pin5PullUp_reg;
    logic                  pin5PullUp_next;
    logic [PFS_NPIN-1:0]   pinLevel_reg;
    logic [PFS_NPIN-1:0]   pinLevel_next;
    logic                  irqZeroSrc_reg;
    logic                  irqZeroSrc_next;
    logic                  timerSrc_reg;
    logic                  timerSrc_next;
    logic                  resetIn_reg;
    logic                  resetIn_next;
    logic                  irqOut_reg;
    logic                  irqOut_next;

    logic [PFS_DW-1:0]     portDirView;
    logic [PFS_DW-1:0]     pullupView;
    logic [PFS_DW-1:0]     portDataView;
    logic                  wrHit;
    logic [PFS_NIRQ-1:0]   irqClr;
    logic                  p1Routed;
    logic                  p5Routed;

    pfs_edge_if edgeBus ();

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    // Input-only pins read as input
    always_comb
    begin
        portDirView  = {2'h0, DIR_INPUT_ALL[PFS_NPIN-1:1], portDirC_reg}; // see (RQ1)
        pullupView   = RST_DATA;
        pullupView[PIN_ZERO] = pullupP0_reg; // see (RQ8)
        pullupView[PIN_FIVE] = pullupP5_reg; // see (RQ8)
        portDataView = {2'h0, pinIn};
        if (!portDirC_reg)
        begin
            portDataView[PIN_ZERO] = portLatch_reg;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb
    begin
        wrHit                  = regWrStb;
        portLatch_next         = portLatch_reg;
        portDirC_next          = portDirC_reg;
        pullupP0_next          = pullupP0_reg;
        pullupP5_next          = pullupP5_reg;
        pinMode_next           = pinMode_reg;
        resetPinAsPortBit_next = resetPinAsPortBit_reg;
        altSwitchCtrl_next     = altSwitchCtrl_reg;
        edgeSel_next           = edgeSel_reg;
        irqEn_next             = irqEn_reg;
        irqClr                 = RST_IRQ;
        if (wrHit && regAddr == ADDR_PORT_DATA)
        begin
            portLatch_next = regWrData[PIN_ZERO];
        end
        else if (wrHit && regAddr == ADDR_PORT_DIR)
        begin
            portDirC_next = regWrData[PIN_ZERO]; // see (RQ7)
        end
        else if (wrHit && regAddr == ADDR_PULLUP)
        begin
            pullupP0_next = regWrData[PIN_ZERO]; // see (RQ8)
            pullupP5_next = regWrData[PIN_FIVE];
        end
        else if (wrHit && regAddr == ADDR_PIN_MODE)
        begin
            pinMode_next = regWrData[PFS_NPIN-1:0];                    // see (RQ9)
        end
        else if (wrHit && regAddr == ADDR_RST_MODE)
        begin
            resetPinAsPortBit_next = regWrData[BIT_RST_AS_PORT];       // see (RQ2)
        end
        else if (wrHit && regAddr == ADDR_ALT_SW)
        begin
            altSwitchCtrl_next = regWrData[2:0];
        end
        else if (wrHit && regAddr == ADDR_EDGE_SEL)
        begin
            edgeSel_next = regWrData[3:0]; // see (RQ10)
        end
        else if (wrHit && regAddr == ADDR_IRQ_CLR)
        begin
            irqClr = regWrData[PFS_NIRQ-1:0];
        end
        else if (wrHit && regAddr == ADDR_IRQ_EN)
        begin
            irqEn_next = regWrData[PFS_NIRQ-1:0];
        end
        // A new edge in the clearing cycle survives
        irqStat_next = edgeBus.hit | (irqStat_reg & ~irqClr);
    end

    // Reset pin starts as the reset input
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portLatch_reg         <= 1'b0;
            portDirC_reg          <= DIR_INPUT_ALL[PIN_ZERO];
            pullupP0_reg          <= 1'b0;
            pullupP5_reg          <= 1'b0;
            pinMode_reg           <= RST_PIN_MODE;
            resetPinAsPortBit_reg <= 1'b0; // see (RQ3)
            altSwitchCtrl_reg     <= RST_ALT_SW;
            edgeSel_reg           <= RST_EDGE_SEL;
            irqStat_reg           <= RST_IRQ;
            irqEn_reg             <= RST_IRQ;
        end
        else
        begin
            portLatch_reg         <= portLatch_next;
            portDirC_reg          <= portDirC_next;
            pullupP0_reg          <= pullupP0_next;
            pullupP5_reg          <= pullupP5_next;
            pinMode_reg           <= pinMode_next;
            resetPinAsPortBit_reg <= resetPinAsPortBit_next;
            altSwitchCtrl_reg     <= altSwitchCtrl_next;
            edgeSel_reg           <= edgeSel_next;
            irqStat_reg           <= irqStat_next;
            irqEn_reg             <= irqEn_next;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdData_next = RST_DATA;
        if (regRdStb && regAddr == ADDR_PORT_DATA)
        begin
            rdData_next = portDataView;
        end
        else if (regRdStb && regAddr == ADDR_PORT_DIR)
        begin
            rdData_next = portDirView;
        end
        else if (regRdStb && regAddr == ADDR_PULLUP)
        begin
            rdData_next = pullupView;
        end
        else if (regRdStb && regAddr == ADDR_PIN_MODE)
        begin
            rdData_next = {2'h0, pinMode_reg};
        end
        else if (regRdStb && regAddr == ADDR_RST_MODE)
        begin
            rdData_next[BIT_RST_AS_PORT] = resetPinAsPortBit_reg;
        end
        else if (regRdStb && regAddr == ADDR_ALT_SW)
        begin
            rdData_next = {5'h00, altSwitchCtrl_reg};
        end
        else if (regRdStb && regAddr == ADDR_EDGE_SEL)
        begin
            rdData_next = {4'h0, edgeSel_reg};
        end
        else if (regRdStb && regAddr == ADDR_IRQ_STAT)
        begin
            rdData_next = {6'h00, irqStat_reg};
        end
        else if (regRdStb && regAddr == ADDR_IRQ_EN)
        begin
            rdData_next = {6'h00, irqEn_reg};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdData_reg <= RST_DATA;
        end
        else
        begin
            rdData_reg <= rdData_next;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and function routing
    // ------------------------------------------------------------
    // Pin five routes only as a port bit
    always_comb
    begin
        p5Routed = altSwitchCtrl_reg[ALT_TMR_IRQ_P5] & resetPinAsPortBit_reg;
        p1Routed = altSwitchCtrl_reg[ALT_TMR_IRQ_P1];
        pinLevel_next = pinIn; // see (RQ13)
        pin0Out_next  = 1'b0;
        pin0Oe_next   = 1'b0;
        if (pinMode_reg[PIN_ZERO])
        begin
            if (altSwitchCtrl_reg[ALT_CSI_P0])
            begin
                pin0Out_next = csiSerialDataOut; // see (RQ6)
                pin0Oe_next  = 1'b1;
            end
        end
        else if (!portDirC_reg)
        begin
            pin0Out_next = portLatch_reg; // see (RQ1)
            pin0Oe_next  = 1'b1; // see (RQ7)
        end
        // Debugger owns tool data direction
        pin2Out_next = progDebugDataOut; // see (RQ12)
        pin2Oe_next  = progDebugMode & progDebugDataOe;                // see (RQ12)
        pin0PullUp_next = pullupP0_reg & ~pin0Oe_next;                 // see (RQ8)
        pin5PullUp_next = pullupP5_reg; // see (RQ8)
        if (p5Routed)
        begin
            irqZeroSrc_next = pinIn[PIN_FIVE]; // see (RQ5)
            timerSrc_next   = pinIn[PIN_FIVE];
        end
        else if (p1Routed)
        begin
            irqZeroSrc_next = pinIn[PIN_ONE]; // see (RQ5)
            timerSrc_next   = pinIn[PIN_ONE];
        end
        else
        begin
            irqZeroSrc_next = pinIn[PIN_ZERO];
            timerSrc_next   = 1'b0;
        end
        // A port-mode reset pin never resets
        resetIn_next = resetPinAsPortBit_reg | pinIn[PIN_FIVE];        // see (RQ4)
        irqOut_next  = |(irqStat_next & irqEn_next);
    end

    // Reset request starts asserted
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin0Out_reg    <= 1'b0;
            pin0Oe_reg     <= 1'b0;
            pin2Out_reg    <= 1'b0;
            pin2Oe_reg     <= 1'b0;
            pin0PullUp_reg <= 1'b0;
            pin5PullUp_reg <= 1'b0;
            pinLevel_reg   <= RST_PIN_MODE;
            irqZeroSrc_reg <= 1'b0;
            timerSrc_reg   <= 1'b0;
            resetIn_reg    <= 1'b0; // see (RQ3)
            irqOut_reg     <= 1'b0;
        end
        else
        begin
            pin0Out_reg    <= pin0Out_next;
            pin0Oe_reg     <= pin0Oe_next;
            pin2Out_reg    <= pin2Out_next;
            pin2Oe_reg     <= pin2Oe_next;
            pin0PullUp_reg <= pin0PullUp_next;
            pin5PullUp_reg <= pin5PullUp_next;
            pinLevel_reg   <= pinLevel_next;
            irqZeroSrc_reg <= irqZeroSrc_next;
            timerSrc_reg   <= timerSrc_next;
            resetIn_reg    <= resetIn_next;
            irqOut_reg     <= irqOut_next;
        end
    end

    // ------------------------------------------------------------
    // Edge interrupts
    // ------------------------------------------------------------
    assign edgeBus.lvl[IRQ_EXT_ZERO] = irqZeroSrc_reg;
    assign edgeBus.lvl[IRQ_TIMER_IN] = timerSrc_reg;
    assign edgeBus.sel               = edgeSel_reg;

    pfs_edge_detect uEdge
    (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .edge_bus (edgeBus)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdData          = rdData_reg;
    assign pin0Out            = pin0Out_reg;
    assign pin0Oe             = pin0Oe_reg;
    assign pin2Out            = pin2Out_reg;
    assign pin2Oe             = pin2Oe_reg;
    assign pin0PullUp         = pin0PullUp_reg;
    assign pin5PullUp         = pin5PullUp_reg;
    assign extIrqZeroIn       = irqZeroSrc_reg;
    assign extLowvoltDetectIn = pinLevel_reg[PIN_ZERO];
    // One level is count clock and capture trigger
    assign timerExtCountIn    = timerSrc_reg; // see (RQ11)
    assign mainOscIn          = pinLevel_reg[PIN_ONE];
    assign mainExtClkIn       = pinLevel_reg[PIN_TWO];
    assign subOscIn           = pinLevel_reg[PIN_THREE];
    assign subExtClkIn        = pinLevel_reg[PIN_FOUR];
    assign progDebugClkIn     = pinLevel_reg[PIN_ONE];                 // see (RQ12)
    assign progDebugDataIn    = pinLevel_reg[PIN_TWO];                 // see (RQ12)
    assign extResetInN        = resetIn_reg;
    assign irqOut             = irqOut_reg;

endmodule : pfs_port12_mux

// [pfs_port12_props.sv]
// Port checks of the port C pin select block.
// Assumes a bind onto pfs_port12_mux; sees its ports only.
module pfs_port12_props
    import pfs_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire logic [PFS_AW-1:0]   regAddr,
    input wire logic                regRdStb,
    input wire logic [PFS_DW-1:0]   regRdData,
    input wire logic [PFS_NPIN-1:0] pinIn,
    input wire logic                pin0Oe,
    input wire logic                pin0PullUp,
    input wire logic                pin2Oe,
    input wire logic                progDebugMode,
    input wire logic                progDebugDataOe,
    input wire logic                progDebugDataIn,
    input wire logic                mainExtClkIn,
    input wire logic                extLowvoltDetectIn,
    input wire logic                extResetInN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    dir_read_a: assert property ($past(regRdStb) && $past(regAddr) == ADDR_PORT_DIR
        |-> regRdData[5:1] == 5'h1F) else $error("dir view");
    pull_read_a: assert property ($past(regRdStb) && $past(regAddr) == ADDR_PULLUP
        |-> {regRdData[7:6], regRdData[4:1]} == 6'h00) else $error("pull view");
    pull_drive_a: assert property (pin0Oe |-> !pin0PullUp)
        else $error("pull on drive");
    rst_high_a: assert property ($past(reset_n) && $past(pinIn[5]) |-> extResetInN)
        else $error("reset while high");
    low_volt_a: assert property ($past(reset_n) |-> extLowvoltDetectIn == $past(pinIn[0]))
        else $error("lowvolt path");
    tool_data_a: assert property ($past(reset_n) |-> progDebugDataIn == $past(pinIn[2]))
        else $error("tool data path");
    shared_in_a: assert property (mainExtClkIn == progDebugDataIn)
        else $error("pin two split");
    tool_oe_a: assert property ($past(reset_n)
        |-> pin2Oe == $past(progDebugMode && progDebugDataOe)) else $error("tool drive wrong");
    cover property ($rose(pin0Oe));
    cover property ($rose(pin2Oe));
    cover property ($rose(extResetInN));
endmodule : pfs_port12_props

bind pfs_port12_mux pfs_port12_props u_props (.*);

// [port12_pin_function_select_bench.sv]
// Self-checking bench of the port C pin select block.
// Assumes the pin model stands for the board; stimulus changes at rising edges.
module port12_pin_function_select_bench
    import pfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0, reset_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00, regRdData;
    logic [5:0]  pinIn, bLvl = 6'h00;
    logic        open0 = 1'b1, pdMode = 1'b0, pdOut = 1'b0, pdOe = 1'b0, csi = 1'b0;
    logic        p0Out, p0Oe, p2Out, p2Oe, p0Pu, p5Pu, tmrIn, rstN, irq, pdIn;
    logic [4:0]  oIn;
    int          err_count = 0, tests_run = 0;
    always #10 clk_sys = ~clk_sys;
    pfs_port12_mux i_dut (.clk_sys, .reset_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
        .regRdData, .pinIn, .pin0Out(p0Out), .pin0Oe(p0Oe), .pin2Out(p2Out), .pin2Oe(p2Oe),
        .pin0PullUp(p0Pu), .pin5PullUp(p5Pu), .progDebugMode(pdMode), .progDebugDataOut(pdOut),
        .progDebugDataOe(pdOe), .csiSerialDataOut(csi), .extIrqZeroIn(oIn[4]),
        .extLowvoltDetectIn(), .timerExtCountIn(tmrIn), .mainOscIn(oIn[0]), .mainExtClkIn(),
        .subOscIn(oIn[1]), .subExtClkIn(oIn[2]), .progDebugClkIn(oIn[3]),
        .progDebugDataIn(pdIn), .extResetInN(rstN), .irqOut(irq));
    pfs_pin_model i_pins (.clk_sys, .boardLvl(bLvl), .open0, .pin0Out(p0Out), .pin0Oe(p0Oe),
        .pin0PullUp(p0Pu), .pin2Out(p2Out), .pin2Oe(p2Oe), .pinLvl(pinIn));
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
            err_count++;
        end
    endtask : chk
    task automatic w(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : w
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk_sys);
        regWrStb  <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge clk_sys);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1;
        chk("regRdData", regRdData, e);
    endtask : rd
    task automatic end_sim;
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Run is about 160 cycles
    initial
    begin
        #100us;
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        w(2);
        chk("rstN", 8'(rstN), 8'h00);
        @(posedge clk_sys) bLvl[5] <= 1'b1;
        w(2);
        chk("rstN", 8'(rstN), 8'h01);
        rd(ADDR_PORT_DIR, 8'h3F);
        wr(ADDR_PORT_DIR, 8'h00);
        rd(ADDR_PORT_DIR, 8'h3E);
        rd(4'hF, 8'h00);
        wr(ADDR_PULLUP, 8'hFF);
        rd(ADDR_PULLUP, 8'h21);
        wr(ADDR_PORT_DATA, 8'h01);
        w(2);
        chk("pin0", {4'h0, p5Pu, p0Pu, p0Oe, p0Out}, 8'h0B);
        rd(ADDR_PORT_DATA, 8'h21);
        wr(ADDR_RST_MODE, 8'h20);
        @(posedge clk_sys) bLvl[5] <= 1'b0;
        w(2);
        chk("rstN", 8'(rstN), 8'h01);
        rd(ADDR_PORT_DATA, 8'h01);
        wr(ADDR_PIN_MODE, 8'h01);
        wr(ADDR_ALT_SW, 8'h04);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk_sys) csi <= v[0];
            w(2);
            chk("csi", {6'h00, p0Oe, p0Out}, {7'h01, v[0]});
        end
        wr(ADDR_ALT_SW, 8'h00);
        wr(ADDR_PIN_MODE, 8'h00);
        wr(ADDR_PORT_DIR, 8'h01);
        @(posedge clk_sys) open0 <= 1'b0;
        wr(ADDR_IRQ_EN, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_EDGE_SEL, 8'(m));
            for (int e = 0; e < 2; e++)
            begin
                wr(ADDR_IRQ_CLR, 8'h03);
                @(posedge clk_sys) bLvl[0] <= ~bLvl[0];
                w(4);
                rd(ADDR_IRQ_STAT, 8'(m[e]));
                chk("irq", 8'(irq), 8'(m[e]));
            end
        end
        wr(ADDR_EDGE_SEL, 8'h04);
        wr(ADDR_ALT_SW, 8'h01);
        wr(ADDR_IRQ_CLR, 8'h03);
        @(posedge clk_sys) bLvl[4:1] <= 4'h5;
        w(4);
        chk("timer", {1'b0, oIn, irq, tmrIn}, 8'h6D);
        rd(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_IRQ_EN, 8'h02);
        w(1);
        chk("irq", 8'(irq), 8'h01);
        wr(ADDR_IRQ_CLR, 8'h02);
        w(1);
        chk("irq", 8'(irq), 8'h00);
        @(posedge clk_sys) {pdMode, pdOe, pdOut} <= 3'b111;
        w(3);
        chk("tool", {6'h00, p2Oe, pdIn}, 8'h03);
        end_sim();
    end
endmodule : port12_pin_function_select_bench
